// file: src/adctrc_pkg.sv
// package for the converter trigger and result control block
// assumes a 32-bit ahb-lite register bus, one word per register
// Summary of operation
// - gain stage is unipolar after reset; bipolar select bit switches to bipolar.
// - unipolar with negative input not below positive saturates result to reference.
// - bipolar results are two's complement, nine magnitude bits plus sign.
// - unipolar results are unsigned with full ten-bit resolution.
// - the two reserved control b bits store and read back what was written.
// - alignment bit one left-adjusts the result, zero right-adjusts it.
// - changing alignment alters presented result at once, even mid-conversion.
// - trigger source field only matters while auto-trigger is enabled.
// - auto-trigger starts a conversion on each rising edge of selected flag.
// - switching from a clear source to a set source counts as rising edge.
// - selecting free running mode never itself produces a trigger event.
// - field decode: free, comparator, ext int 0, t0 cmpA, t0 ovf, t1 cmpB/ovf/capture.
// - each set input disable bit switches off that analog pin's digital buffer.
// - a disabled pin reads zero in the port input register.
// - conversion done flag sets on a core result unless a low byte read has frozen the results; free-running source.
// - low byte read freezes result registers until high byte is read.
// - left form puts bits 9..2 high, 1..0 low[7:6]; right form 9..8 high[1:0].
package adctrc_pkg;
  // register index in the byte-wide map; each register sits in its own word
  localparam logic [9:0] IDX_PIN_DISABLE = 10'h001;
  localparam logic [9:0] IDX_RESULT_LOW = 10'h004;
  localparam logic [9:0] IDX_RESULT_HIGH = 10'h005;
  localparam logic [9:0] IDX_CTRL_A = 10'h006;
  localparam logic [11:0] ADDR_PIN_DISABLE = {IDX_PIN_DISABLE, 2'h0};
  localparam logic [11:0] ADDR_CTRL_B = 12'h00C;
  localparam logic [11:0] ADDR_CTRL_A = {IDX_CTRL_A, 2'h0};
  localparam logic [11:0] ADDR_RESULT_LOW = {IDX_RESULT_LOW, 2'h0};
  localparam logic [11:0] ADDR_RESULT_HIGH = {IDX_RESULT_HIGH, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h020;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h024;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h028;
  localparam logic [11:0] ADDR_PORT_INPUT = 12'h02C;
  localparam int CTRLB_BIPOLAR = 7;
  localparam int CTRLB_COMP_MUX = 6;
  localparam int CTRLB_LEFT_ALIGN = 4;
  localparam int CTRLA_ENABLE = 7;
  localparam int CTRLA_START = 6;
  localparam int CTRLA_AUTO = 5;
  localparam int CTRLA_DONE = 4;
  localparam logic [7:0] CTRLB_RESET = 8'h00;
  localparam logic [7:0] CTRLA_RESET = 8'h00;
  localparam logic [7:0] PIN_DISABLE_RESET = 8'h00;
  localparam logic [9:0] RESULT_SATURATED = 10'h3FF;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRIGGER = 1;
  typedef enum logic [2:0] {
    TRIG_FREE_RUN, TRIG_COMPARATOR, TRIG_EXT_INT0, TRIG_T0_CMP_A,
    TRIG_T0_OVF, TRIG_T1_CMP_B, TRIG_T1_OVF, TRIG_T1_CAPTURE
  } adctrc_trig_t;
  typedef struct packed {
    logic t1_capture;
    logic t1_ovf;
    logic t1_cmp_b;
    logic t0_ovf;
    logic t0_cmp_a;
    logic ext_int0;
    logic comparator;
  } adctrc_flags_t;
  typedef struct packed {
    logic valid;
    logic [9:0] raw;
    logic below;
  } adctrc_core_t;
endpackage : adctrc_pkg

// file: src/adctrc_top.sv
// converter trigger, result formatting and analog pin input control
// assumes flags and core result on clk_sys; pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
module adctrc_top
  import adctrc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // trigger flags and conversion core
  input wire adctrc_flags_t trig_flags,
  input wire adctrc_core_t core_result,
  output logic conv_start,
  output logic converter_enable,
  output logic bipolar_select,
  output logic comparator_mux_enable,
  // analog pins
  input wire logic [7:0] pin_level,
  output logic [7:0] pin_digital_input_off,
  // interrupt
  output logic irq
);
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] pin_dis_reg;
  logic [9:0] result_reg;
  logic [9:0] hold_reg;
  logic frozen_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_en_reg;
  logic sel_flag_reg;
  logic start_reg;
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  logic [11:0] addr_reg;
  logic wr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic irq_reg;

  wire logic phase_ok = hsel & hready & htrans[1];
  wire logic wr_en = wr_reg;
  wire logic [7:0] wbyte = hwdata[7:0];
  wire logic done_w1 = wr_en && addr_reg == ADDR_CTRL_A && wbyte[CTRLA_DONE];
  wire logic auto_on = ctrl_a_reg[CTRLA_AUTO];
  wire logic conv_on = ctrl_a_reg[CTRLA_ENABLE];
  wire adctrc_trig_t trig_sel = adctrc_trig_t'(ctrl_b_reg[2:0]);
  wire logic left_align = ctrl_b_reg[CTRLB_LEFT_ALIGN];

  logic sel_flag;
  always_comb begin
    case (trig_sel)
      TRIG_FREE_RUN: sel_flag = ctrl_a_reg[CTRLA_DONE];
      TRIG_COMPARATOR: sel_flag = trig_flags.comparator;
      TRIG_EXT_INT0: sel_flag = trig_flags.ext_int0;
      TRIG_T0_CMP_A: sel_flag = trig_flags.t0_cmp_a;
      TRIG_T0_OVF: sel_flag = trig_flags.t0_ovf;
      TRIG_T1_CMP_B: sel_flag = trig_flags.t1_cmp_b;
      TRIG_T1_OVF: sel_flag = trig_flags.t1_ovf;
      TRIG_T1_CAPTURE: sel_flag = trig_flags.t1_capture;
      default: sel_flag = 1'b0;
    endcase
  end

  // free running switch is no edge
  logic free_prev_reg;
  wire logic switched_to_free = (trig_sel == TRIG_FREE_RUN) & ~free_prev_reg;
  // edge of selected flag, across source switches too
  wire logic trig_edge = sel_flag & ~sel_flag_reg & ~switched_to_free;
  // field only used in auto mode
  wire logic auto_start = auto_on & conv_on & trig_edge;
  wire logic sw_start = wr_en && addr_reg == ADDR_CTRL_A && wbyte[CTRLA_START]
                        && wbyte[CTRLA_ENABLE];

  logic [9:0] shaped;
  always_comb begin
    if (!bipolar_select && core_result.below) begin
      shaped = RESULT_SATURATED;
    end else begin
      shaped = core_result.raw;
    end
  end

  // alignment applied on read, so it is immediate
  wire logic [9:0] shown = frozen_reg ? hold_reg : result_reg;
  wire logic [7:0] res_low = left_align ? {shown[1:0], 6'h00} : shown[7:0];
  wire logic [7:0] res_high = left_align ? shown[9:2] : {6'h00, shown[9:8]};
  wire logic [7:0] port_in = pin_s2_reg & ~pin_dis_reg;

  always_comb begin
    case (addr_reg)
      ADDR_PIN_DISABLE: hrdata_next = {24'h000000, pin_dis_reg};
      ADDR_CTRL_B: hrdata_next = {24'h000000, ctrl_b_reg};
      ADDR_CTRL_A: hrdata_next = {24'h000000, ctrl_a_reg};
      ADDR_RESULT_LOW: hrdata_next = {24'h000000, res_low};
      ADDR_RESULT_HIGH: hrdata_next = {24'h000000, res_high};
      ADDR_IRQ_STATUS: hrdata_next = {30'h0, irq_stat_reg};
      ADDR_IRQ_ENABLE: hrdata_next = {30'h0, irq_en_reg};
      ADDR_PORT_INPUT: hrdata_next = {24'h000000, port_in};
      default: hrdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg <= 12'h000;
      wr_reg <= 1'b0;
    end else begin
      addr_reg <= phase_ok ? haddr[11:0] : addr_reg;
      wr_reg <= phase_ok & hwrite;
    end
  end

  // read data is produced in the data phase combinationally, registered out next
  // cycle: one wait state on reads, none on writes
  logic rd_wait_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_wait_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
    end else begin
      rd_wait_reg <= phase_ok & ~hwrite;
      hrdata_reg <= rd_wait_reg ? hrdata_next : hrdata_reg;
    end
  end
  // hreadyout low during the first data-phase cycle of a read
  logic ready_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= ~(phase_ok & ~hwrite);
    end
  end

  wire logic rd_low = rd_wait_reg && addr_reg == ADDR_RESULT_LOW;
  wire logic rd_high = rd_wait_reg && addr_reg == ADDR_RESULT_HIGH;
  wire logic wr_ctrl_b = wr_en && addr_reg == ADDR_CTRL_B;
  wire logic wr_pin_dis = wr_en && addr_reg == ADDR_PIN_DISABLE;
  wire logic wr_irq_en = wr_en && addr_reg == ADDR_IRQ_ENABLE;

  // whole byte stored, reserved bits included
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_b_reg <= CTRLB_RESET;
    end else if (wr_ctrl_b) begin
      ctrl_b_reg <= wbyte;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_dis_reg <= PIN_DISABLE_RESET;
    end else if (wr_pin_dis) begin
      pin_dis_reg <= wbyte;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_reg <= 2'h0;
    end else if (wr_irq_en) begin
      irq_en_reg <= hwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_reg <= CTRLA_RESET;
    end else begin
      if (wr_en && addr_reg == ADDR_CTRL_A) begin
        ctrl_a_reg[CTRLA_ENABLE] <= wbyte[CTRLA_ENABLE];
        ctrl_a_reg[CTRLA_AUTO] <= wbyte[CTRLA_AUTO];
        ctrl_a_reg[3:0] <= wbyte[3:0];
      end
      // start bit reads one while a conversion runs, except one started by the same write that enables the converter
      if (core_result.valid || !conv_on) begin
        ctrl_a_reg[CTRLA_START] <= 1'b0;
      end else if (sw_start || auto_start) begin
        ctrl_a_reg[CTRLA_START] <= 1'b1;
      end
      // done flag: set wins over write-one clear
      if (core_result.valid && !frozen_reg) begin
        ctrl_a_reg[CTRLA_DONE] <= 1'b1;
      end else if (done_w1) begin
        ctrl_a_reg[CTRLA_DONE] <= 1'b0;
      end
    end
  end

  // low read freezes, high read releases
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= 10'h000;
      hold_reg <= 10'h000;
      frozen_reg <= 1'b0;
    end else begin
      if (core_result.valid) begin
        result_reg <= shaped;
      end
      if (rd_low) begin
        hold_reg <= shown;
        frozen_reg <= 1'b1;
      end else if (rd_high) begin
        frozen_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_flag_reg <= 1'b0;
      free_prev_reg <= 1'b1;
      start_reg <= 1'b0;
    end else begin
      sel_flag_reg <= sel_flag;
      free_prev_reg <= trig_sel == TRIG_FREE_RUN;
      start_reg <= sw_start | auto_start;
    end
  end

  // pins are asynchronous: two-stage synchroniser
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= pin_level;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // sticky status; set wins over clear
  wire logic [1:0] irq_set = {auto_start, core_result.valid & ~frozen_reg};
  wire logic [1:0] irq_clr = (wr_en && addr_reg == ADDR_IRQ_CLEAR) ? hwdata[1:0] : 2'h0;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
      irq_reg <= |((irq_set | (irq_stat_reg & ~irq_clr)) & irq_en_reg);
    end
  end

  logic enable_out_reg;
  logic bip_out_reg;
  logic comparator_mux_enable_out_reg;
  logic [7:0] dis_out_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      enable_out_reg <= 1'b0;
      bip_out_reg <= 1'b0;
      comparator_mux_enable_out_reg <= 1'b0;
      dis_out_reg <= 8'h00;
    end else begin
      enable_out_reg <= conv_on;
      bip_out_reg <= ctrl_b_reg[CTRLB_BIPOLAR];
      comparator_mux_enable_out_reg <= ctrl_b_reg[CTRLB_COMP_MUX];
      dis_out_reg <= pin_dis_reg;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = 1'b0;
  assign conv_start = start_reg;
  assign converter_enable = enable_out_reg;
  assign bipolar_select = bip_out_reg;
  assign comparator_mux_enable = comparator_mux_enable_out_reg;
  assign pin_digital_input_off = dis_out_reg;
  assign irq = irq_reg;
endmodule : adctrc_top
`default_nettype wire

// file: verif/adctrc_asserts.sv
// port assertions for the trigger and result control block
// assumes one bus master; bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module adctrc_asserts (
  // clock, reset and bus
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // converter side
  input wire logic conv_start,
  input wire logic converter_enable,
  input wire logic bipolar_select,
  input wire logic [7:0] pin_digital_input_off,
  input wire logic irq
);
  wire logic req;
  logic [2:0] age_reg;
  assign req = hsel && hready && htrans[1];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // outputs copy registers a cycle late, so only long quiet spells count
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) age_reg <= 3'h7;
    else if (req && hwrite) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  chk_resp_okay: assert property (hresp == 1'b0) else $error("bad resp");
  chk_write_nowait: assert property (req && hwrite |=> hreadyout) else $error("wr wait");
  chk_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("rd wait");
  chk_read_upper: assert property (req && !hwrite |=> ##1 hrdata[31:8] == 24'h0)
    else $error("rd upper");
  chk_idle_ready: assert property (!req && hreadyout |=> hreadyout) else $error("idle");
  chk_start_pulse: assert property (conv_start |=> !conv_start) else $error("pulse");
  chk_start_enabled: assert property (conv_start |=> converter_enable)
    else $error("start off");
  chk_pins_hold: assert property (age_reg == 3'h7 |-> $stable(pin_digital_input_off))
    else $error("pins moved");
  chk_mode_hold: assert property (age_reg == 3'h7 |-> $stable(bipolar_select))
    else $error("mode moved");
  cover property (conv_start);
  cover property ($rose(irq));
  cover property (req && !hwrite);
endmodule : adctrc_asserts
`default_nettype wire

// file: verif/adctrc_core_model.sv
// conversion core model: answers a start five cycles later; a new start restarts the count
// assumes conv_start is a one-cycle pulse on clk_sys
`timescale 1ns/100ps
`default_nettype none
module adctrc_core_model
  import adctrc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // start from the block, sample set by the bench
  input wire logic conv_start,
  input wire logic [9:0] raw_val,
  input wire logic below_val,
  // result to the block
  output var adctrc_core_t core_result
);
  logic [2:0] busy_reg;
  wire logic fin;
  assign fin = busy_reg == 3'h1;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 3'h0;
      core_result <= '0;
    end else begin
      busy_reg <= conv_start ? 3'h4 : busy_reg - 3'(busy_reg != 3'h0);
      core_result.valid <= fin;
      // junk outside the valid cycle, so a stale sample is never reused
      core_result.raw <= fin ? raw_val : ~core_result.raw;
      core_result.below <= fin ? below_val : ~core_result.below;
    end
  end
endmodule : adctrc_core_model
`default_nettype wire

// file: verif/adctrc_tb_top.sv
// bench for the trigger and result control block
// assumes the core model on the far side and one bus master
`timescale 1ns/100ps
`default_nettype none
module adctrc_tb_top
  import adctrc_pkg::*;
;
  logic clk_sys, arst_n, hsel, hwrite, hresp, hreadyout, conv_start, irq, below_val;
  logic converter_enable, bipolar_select, comparator_mux_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] pin_level, pin_digital_input_off;
  logic [9:0] raw_val;
  adctrc_flags_t trig_flags;
  adctrc_core_t core_result;
  int miscompares, cmp_count, starts, n;
  adctrc_top u_adctrc_top (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .trig_flags, .core_result,
    .conv_start, .converter_enable, .bipolar_select, .comparator_mux_enable, .pin_level,
    .pin_digital_input_off, .irq);
  adctrc_core_model u_adctrc_core_model (.clk_sys, .arst_n, .conv_start, .raw_val, .below_val,
    .core_result);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (conv_start === 1'b1) starts <= starts + 1;
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  task wt(input logic on_irq);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while ((on_irq ? irq : hreadyout) !== 1'b1 && k < 64);
    if ((on_irq ? irq : hreadyout) !== 1'b1) begin
      miscompares++;
      summarize();
    end
  endtask : wt
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt(1'b0);
    rd = hrdata;
  endtask : xfer
  task rc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rc
  task t_regs;
    rc(ADDR_CTRL_B, 0);
    rc(12'h3FC, 0);
    xfer(1'b1, ADDR_CTRL_B, 8'h28);
    rc(ADDR_CTRL_B, 32'h28);
    xfer(1'b1, ADDR_CTRL_B, 8'hC0);
    cyc(2);
    chk(bipolar_select, 1'b1);
    chk(comparator_mux_enable, 1'b1);
    xfer(1'b1, ADDR_CTRL_B, 8'h00);
    pin_level <= 8'hFF;
    xfer(1'b1, ADDR_PIN_DISABLE, 8'hA5);
    rc(ADDR_PIN_DISABLE, 32'hA5);
    chk(pin_digital_input_off, 8'hA5);
    rc(ADDR_PORT_INPUT, 32'h5A);
  endtask : t_regs
  task conv(input logic [9:0] raw, input logic below, input logic [15:0] exp);
    raw_val <= raw;
    below_val <= below;
    xfer(1'b1, ADDR_IRQ_CLEAR, 8'h03);
    xfer(1'b1, ADDR_IRQ_ENABLE, 8'h01);
    xfer(1'b1, ADDR_CTRL_A, 8'hC0);
    wt(1'b1);
    rc(ADDR_RESULT_LOW, exp[7:0]);
    rc(ADDR_RESULT_HIGH, exp[15:8]);
  endtask : conv
  task t_conv;
    conv(10'h2C7, 1'b0, 16'h02C7);
    xfer(1'b1, ADDR_CTRL_B, 8'h10);
    rc(ADDR_RESULT_LOW, 32'hC0);
    raw_val <= 10'h155;
    xfer(1'b1, ADDR_CTRL_A, 8'hC0);
    cyc(10);
    rc(ADDR_RESULT_HIGH, 32'hB1);
    rc(ADDR_RESULT_LOW, 32'h40);
    rc(ADDR_RESULT_HIGH, 32'h55);
    xfer(1'b1, ADDR_IRQ_ENABLE, 8'h00);
    cyc(2);
    chk(irq, 1'b0);
    rc(ADDR_IRQ_STATUS, 32'h1);
    xfer(1'b1, ADDR_IRQ_CLEAR, 8'h01);
    rc(ADDR_IRQ_STATUS, 0);
    xfer(1'b1, ADDR_CTRL_B, 8'h00);
    conv(10'h155, 1'b1, 16'h03FF);
    xfer(1'b1, ADDR_CTRL_B, 8'h80);
    conv(10'h3F0, 1'b1, 16'h03F0);
  endtask : t_conv
  task t_trig;
    xfer(1'b1, ADDR_CTRL_B, 8'h01);
    xfer(1'b1, ADDR_CTRL_A, 8'hA0);
    for (int s = 1; s < 8; s++) begin
      xfer(1'b1, ADDR_CTRL_B, 8'(s));
      n = starts;
      trig_flags <= adctrc_flags_t'(7'h01 << (s - 1));
      cyc(3);
      trig_flags <= '0;
      cyc(8);
      chk(starts, n + 1);
    end
    n = starts;
    xfer(1'b1, ADDR_CTRL_B, 8'h00);
    cyc(8);
    chk(starts, n);
    trig_flags <= adctrc_flags_t'(7'h01);
    xfer(1'b1, ADDR_CTRL_B, 8'h03);
    n = starts;
    xfer(1'b1, ADDR_CTRL_B, 8'h01);
    cyc(4);
    chk(starts, n + 1);
    xfer(1'b1, ADDR_CTRL_A, 8'h80);
    trig_flags <= '0;
    cyc(2);
    chk(converter_enable, 1'b1);
    n = starts;
    trig_flags <= adctrc_flags_t'(7'h01);
    cyc(6);
    chk(starts, n);
  endtask : t_trig
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    trig_flags = '0;
    pin_level = 8'h00;
    raw_val = 10'h000;
    below_val = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    starts = 0;
    cyc(20);
    arst_n <= 1'b1;
    t_regs();
    t_conv();
    t_trig();
    summarize();
  end
endmodule : adctrc_tb_top
bind adctrc_top adctrc_asserts u_adctrc_asserts (.clk_sys, .arst_n, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .conv_start, .converter_enable, .bipolar_select,
  .pin_digital_input_off, .irq);
`default_nettype wire
